// ===== logic/primitive_object_setup.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module primitive_object_setup import setup_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic vertexValid,
    output logic vertexReady,
    input wire vertex_s vertexIn,
    output logic objectValid,
    input wire logic objectReady,
    output object_s objectOut
);
    // setup state block
    logic [CTRL_WIDTH-1:0] ctrl_q; // mode bits
    logic [15:0] pointWidth_q; // fixed width, u8.8 pixels
    logic [31:0] drawOrigin_q; // y in [31:16], x in [15:0], signed pixels
    logic [31:0] viewportMem [VIEWPORT_COUNT][VIEWPORT_WORDS]; // descriptor table
    logic [31:0] nanCull_q; // objects dropped for nan
    logic [31:0] degenCull_q; // objects dropped as degenerate
    logic [31:0] objCount_q; // objects handed downstream
    logic [31:0] prdata_q;
    logic pslverr_q;
    // pipeline state
    setup_state_e state_q;
    vertex_s slot_q [3]; // vertices of the object being gathered
    logic [1:0] cnt_q; // vertices gathered so far
    object_s outObj_q;
    // apb decode
    logic setupPhase;
    logic accessPhase;
    logic [11:0] vpOff;
    logic [3:0] vpEntry;
    logic [2:0] vpWord;
    logic vpHit;
    logic regHit;
    logic roHit;
    logic [31:0] readMux;

    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign vpOff = paddr - VIEWPORT_BASE;
    assign vpEntry = vpOff[8:5];
    assign vpWord = vpOff[4:2];
    assign vpHit = (paddr >= VIEWPORT_BASE) && (vpOff[11:9] == 3'h0)
        && (vpWord < 3'(VIEWPORT_WORDS)) && (paddr[1:0] == 2'h0);
    assign pready = 1'b1; // answer is prepared in the setup cycle
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // byte-lane merge for apb4 strobes
    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // read mux and address classification
    always_comb begin
        readMux = 32'h0000_0000;
        regHit = 1'b1;
        roHit = 1'b0;
        unique case (paddr)
            CTRL_OFFSET: readMux = {25'h0, ctrl_q};
            POINT_WIDTH_OFFSET: readMux = {16'h0, pointWidth_q};
            DRAW_ORIGIN_OFFSET: readMux = drawOrigin_q;
            NAN_CULL_OFFSET: begin
                readMux = nanCull_q;
                roHit = 1'b1;
            end
            DEGEN_CULL_OFFSET: begin
                readMux = degenCull_q;
                roHit = 1'b1;
            end
            OBJECT_COUNT_OFFSET: begin
                readMux = objCount_q;
                roHit = 1'b1;
            end
            default: begin
                regHit = 1'b0;
                if (vpHit) begin
                    readMux = viewportMem[vpEntry][vpWord];
                end
            end
        endcase
    end

    // answer captured at the setup edge so prdata comes from a flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setupPhase) begin
            prdata_q <= pwrite ? 32'h0000_0000 : readMux;
            // unmapped address, or write to a counter, is an error
            pslverr_q <= !(regHit || vpHit) || (pwrite && roHit);
        end
    end

    // software-written state; writes take effect at the access edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RESET;
            pointWidth_q <= POINT_WIDTH_RESET;
            drawOrigin_q <= DRAW_ORIGIN_RESET;
        end else if (accessPhase && pwrite) begin
            if (paddr == CTRL_OFFSET) begin
                ctrl_q <= CTRL_WIDTH'(laneMerge({25'h0, ctrl_q}, pwdata, pstrb));
            end
            if (paddr == POINT_WIDTH_OFFSET) begin
                pointWidth_q <= 16'(laneMerge({16'h0, pointWidth_q}, pwdata, pstrb));
            end
            if (paddr == DRAW_ORIGIN_OFFSET) begin
                drawOrigin_q <= laneMerge(drawOrigin_q, pwdata, pstrb);
            end
        end
    end

    // viewport descriptor table, filled by software
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int e = 0; e < VIEWPORT_COUNT; e++) begin
                for (int k = 0; k < VIEWPORT_WORDS; k++) begin
                    viewportMem[e][k] <= VIEWPORT_RESET;
                end
            end
        end else if (accessPhase && pwrite && vpHit) begin
            viewportMem[vpEntry][vpWord] <= laneMerge(viewportMem[vpEntry][vpWord], pwdata, pstrb);
        end
    end

    // s15.16 scale and translate; top bit flags a result that is not a number
    function automatic logic [32:0] scaleShift(input logic signed [31:0] v,
                                               input logic signed [31:0] m,
                                               input logic signed [31:0] t);
        logic signed [63:0] prod;
        logic signed [64:0] sum;
        prod = v * m;
        sum = 65'(prod >>> 16) + 65'(t);
        return {!((&sum[64:31]) || !(|sum[64:31])), sum[31:0]};
    endfunction

    // round to subpixel, ties to even, then clamp to the guardband
    function automatic logic [23:0] quantClamp(input logic signed [33:0] v, input logic fine);
        logic signed [25:0] keep8;
        logic signed [21:0] keep12;
        logic up8;
        logic up12;
        logic signed [26:0] r;
        keep8 = v[33:8];
        keep12 = v[33:12];
        up8 = (v[7:0] > 8'h80) || ((v[7:0] == 8'h80) && keep8[0]);
        up12 = (v[11:0] > 12'h800) || ((v[11:0] == 12'h800) && keep12[0]);
        if (fine) begin
            r = 27'(keep8) + {26'h0, up8};
        end else begin
            r = {23'(keep12) + {22'h0, up12}, 4'h0};
        end
        if (r < GUARD_MIN) begin
            r = GUARD_MIN;
        end else if (r > GUARD_MAX) begin
            r = GUARD_MAX;
        end
        return r[23:0];
    endfunction

    // per-object datapath, evaluated while in PROCESS
    logic [3:0] leadIndex;
    logic inNan;
    logic postNan;
    logic signed [33:0] px [3];
    logic signed [33:0] py [3];
    logic signed [33:0] cx [4];
    logic signed [33:0] cy [4];
    logic signed [33:0] halfW;
    logic [23:0] qx [4];
    logic [23:0] qy [4];
    logic [31:0] tz [3];
    logic [32:0] tx;
    logic [32:0] ty;
    logic [32:0] tzz;
    logic signed [24:0] dx1;
    logic signed [24:0] dy1;
    logic signed [24:0] dx2;
    logic signed [24:0] dy2;
    logic degenerate;
    logic [1:0] need;
    object_kind_e kind;
    object_s nextObj;

    always_comb begin
        leadIndex = slot_q[0].viewportSelectIndex;
        inNan = 1'b0;
        postNan = 1'b0;
        tx = 33'h0;
        ty = 33'h0;
        tzz = 33'h0;
        for (int i = 0; i < 3; i++) begin
            if (i <= int'(need) - 1) begin
                inNan = inNan || (|slot_q[i].nanFlags);
            end
            if (ctrl_q[CTRL_VIEWPORT_EN_BIT]) begin
                tx = scaleShift(slot_q[i].x, viewportMem[leadIndex][VP_M00],
                    viewportMem[leadIndex][VP_M30]);
                ty = scaleShift(slot_q[i].y, viewportMem[leadIndex][VP_M11],
                    viewportMem[leadIndex][VP_M31]);
                tzz = scaleShift(slot_q[i].z, viewportMem[leadIndex][VP_M22],
                    viewportMem[leadIndex][VP_M32]);
                if (i <= int'(need) - 1) begin
                    postNan = postNan || tx[32] || ty[32] || tzz[32];
                end
            end else begin
                tx = {1'b0, slot_q[i].x};
                ty = {1'b0, slot_q[i].y};
                tzz = {1'b0, slot_q[i].z};
            end
            tz[i] = tzz[31:0];
            // grid bias then drawing origin, which has no disable
            px[i] = 34'($signed(tx[31:0]))
                - (ctrl_q[CTRL_BIAS_H_BIT] ? HALF_PIXEL : 34'sh0)
                + 34'($signed({drawOrigin_q[15:0], 16'h0}));
            py[i] = 34'($signed(ty[31:0]))
                - (ctrl_q[CTRL_BIAS_V_BIT] ? HALF_PIXEL : 34'sh0)
                + 34'($signed({drawOrigin_q[31:16], 16'h0}));
        end
        // half of the point width, u8.8 moved to s15.16
        halfW = ctrl_q[CTRL_WIDTH_FROM_VERTEX_BIT]
            ? 34'({slot_q[0].pointWidth, 7'h0}) : 34'({pointWidth_q, 7'h0});
        unique case (kind)
            POINT_OBJECT: begin
                // corners ordered lr, ll, ul, ur like a rectangle
                cx[0] = px[0] + halfW;
                cy[0] = py[0] + halfW;
                cx[1] = px[0] - halfW;
                cy[1] = py[0] + halfW;
                cx[2] = px[0] - halfW;
                cy[2] = py[0] - halfW;
                cx[3] = px[0] + halfW;
                cy[3] = py[0] - halfW;
            end
            RECTANGLE_OBJECT: begin
                cx[0] = px[0];
                cy[0] = py[0];
                cx[1] = px[1];
                cy[1] = py[1];
                cx[2] = px[2];
                cy[2] = py[2];
                cx[3] = px[0];
                cy[3] = py[2];
            end
            default: begin
                cx[0] = px[0];
                cy[0] = py[0];
                cx[1] = px[1];
                cy[1] = py[1];
                cx[2] = px[2];
                cy[2] = py[2];
                cx[3] = 34'sh0;
                cy[3] = 34'sh0;
            end
        endcase
        // quantize and clamp only after offset and expansion
        for (int c = 0; c < 4; c++) begin
            qx[c] = quantClamp(cx[c], ctrl_q[CTRL_FINE_SUBPIXEL_BIT]);
            qy[c] = quantClamp(cy[c], ctrl_q[CTRL_FINE_SUBPIXEL_BIT]);
        end
        dx1 = 25'($signed(qx[1])) - 25'($signed(qx[0]));
        dy1 = 25'($signed(qy[1])) - 25'($signed(qy[0]));
        dx2 = 25'($signed(qx[2])) - 25'($signed(qx[0]));
        dy2 = 25'($signed(qy[2])) - 25'($signed(qy[0]));
        degenerate = 1'b0;
        unique case (kind)
            POINT_OBJECT, RECTANGLE_OBJECT: begin
                for (int a = 0; a < 4; a++) begin
                    for (int b = a + 1; b < 4; b++) begin
                        if (qx[a] == qx[b] && qy[a] == qy[b]) begin
                            degenerate = 1'b1;
                        end
                    end
                end
            end
            LINE_OBJECT: degenerate = (qx[0] == qx[1]) && (qy[0] == qy[1]);
            TRIANGLE_OBJECT: begin
                // zero cross product also covers coincident vertices
                degenerate = ctrl_q[CTRL_SOLID_FILL_BIT]
                    && (50'(dx1 * dy2) == 50'(dy1 * dx2));
            end
        endcase
        nextObj.objectKindTag = kind;
        nextObj.fineSubpixel = ctrl_q[CTRL_FINE_SUBPIXEL_BIT];
        nextObj.upperLeftEdgeRule = ctrl_q[CTRL_UPPER_LEFT_RULE_BIT];
        for (int c = 0; c < 4; c++) begin
            nextObj.x[c] = qx[c];
            nextObj.y[c] = qy[c];
            if (kind == POINT_OBJECT) begin
                nextObj.z[c] = tz[0];
                nextObj.w[c] = slot_q[0].reciprocalW;
            end else if (c < 3) begin
                nextObj.z[c] = tz[c];
                nextObj.w[c] = slot_q[c].reciprocalW;
            end else begin
                // implied corner attributes are unused downstream
                nextObj.z[c] = 32'h0000_0000;
                nextObj.w[c] = 32'h0000_0000;
            end
        end
    end

    // topology of the group's first vertex sets kind and group size
    topology_e groupTopo;
    assign groupTopo = (cnt_q == 2'h0) ? vertexIn.topology : slot_q[0].topology;
    always_comb begin
        unique case ((state_q == COLLECT) ? groupTopo : slot_q[0].topology)
            POINT_LIST_TOPOLOGY: begin
                need = 2'h1;
                kind = POINT_OBJECT;
            end
            LINE_LIST_TOPOLOGY: begin
                need = 2'h2;
                kind = LINE_OBJECT;
            end
            TRIANGLE_LIST_TOPOLOGY: begin
                need = 2'h3;
                kind = TRIANGLE_OBJECT;
            end
            RECT_LIST_TOPOLOGY: begin
                need = 2'h3;
                kind = RECTANGLE_OBJECT;
            end
        endcase
    end

    logic culled;
    assign culled = inNan || postNan || degenerate;
    assign vertexReady = (state_q == COLLECT);
    assign objectValid = (state_q == EMIT);
    assign objectOut = outObj_q;

    // gather vertices, process one object, hand it on
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= COLLECT;
            cnt_q <= 2'h0;
            for (int i = 0; i < 3; i++) begin
                slot_q[i] <= '0;
            end
        end else begin
            unique case (state_q)
                COLLECT: begin
                    if (vertexValid) begin
                        slot_q[cnt_q] <= vertexIn;
                        if (cnt_q + 2'h1 == need) begin
                            cnt_q <= 2'h0;
                            state_q <= PROCESS;
                        end else if (vertexIn.primEnd) begin
                            cnt_q <= 2'h0; // partial group at list end is dropped
                        end else begin
                            cnt_q <= cnt_q + 2'h1;
                        end
                    end
                end
                PROCESS: state_q <= culled ? COLLECT : EMIT;
                EMIT: begin
                    if (objectReady) begin
                        state_q <= COLLECT;
                    end
                end
            endcase
        end
    end

    // output object register, held through back-pressure
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outObj_q <= '0;
        end else if (state_q == PROCESS && !culled) begin
            outObj_q <= nextObj;
        end
    end

    // statistics counters, read-only to software
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nanCull_q <= 32'h0000_0000;
            degenCull_q <= 32'h0000_0000;
            objCount_q <= 32'h0000_0000;
        end else if (state_q == PROCESS) begin
            if (inNan || postNan) begin
                nanCull_q <= nanCull_q + 32'h1;
            end else if (degenerate) begin
                degenCull_q <= degenCull_q + 32'h1;
            end else begin
                objCount_q <= objCount_q + 32'h1;
            end
        end
    end

    chk_rect_upper_right: assert property (@(posedge clk) disable iff (!rst_b)
        objectValid && objectOut.objectKindTag == RECTANGLE_OBJECT
        |-> objectOut.x[3] == objectOut.x[0] && objectOut.y[3] == objectOut.y[2])
        else $error("rect upper right corner not built from lr x and ul y");
    chk_point_zw_copy: assert property (@(posedge clk) disable iff (!rst_b)
        objectValid && objectOut.objectKindTag == POINT_OBJECT
        |-> objectOut.z[1] == objectOut.z[0] && objectOut.z[3] == objectOut.z[0]
            && objectOut.w[2] == objectOut.w[0])
        else $error("point corners do not share center z and w");
    chk_guard_range: assert property (@(posedge clk) disable iff (!rst_b)
        objectValid |-> $signed(objectOut.x[1]) <= 24'sh7fff00
            && $signed(objectOut.y[2]) <= 24'sh7fff00)
        else $error("output xy beyond guardband");
    chk_coarse_subpixel: assert property (@(posedge clk) disable iff (!rst_b)
        objectValid && !objectOut.fineSubpixel |-> objectOut.x[0][3:0] == 4'h0
            && objectOut.y[1][3:0] == 4'h0)
        else $error("coarse precision kept more than 4 fraction bits");
    chk_nan_cull: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == PROCESS && inNan |=> state_q == COLLECT ##1 !objectValid)
        else $error("object with nan input was not dropped");
    chk_line_distinct: assert property (@(posedge clk) disable iff (!rst_b)
        objectValid && objectOut.objectKindTag == LINE_OBJECT
        |-> objectOut.x[0] != objectOut.x[1] || objectOut.y[0] != objectOut.y[1])
        else $error("coincident line endpoints reached output");
    chk_square_distinct: assert property (@(posedge clk) disable iff (!rst_b)
        objectValid && objectOut.objectKindTag == POINT_OBJECT
        |-> objectOut.x[0] != objectOut.x[1] && objectOut.y[1] != objectOut.y[2])
        else $error("collapsed point square reached output");
    chk_rect_kind: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == PROCESS && !culled && slot_q[0].topology == RECT_LIST_TOPOLOGY
        |=> objectValid && objectOut.objectKindTag == RECTANGLE_OBJECT)
        else $error("rect list object not tagged as rectangle");
    chk_output_hold: assert property (@(posedge clk) disable iff (!rst_b)
        objectValid && !objectReady |=> objectValid && $stable(objectOut))
        else $error("output object changed while stalled");
endmodule // primitive_object_setup
`default_nettype wire

// ===== logic/setup_pkg.sv
`default_nettype none
package setup_pkg;
    // register byte offsets on the apb port
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] POINT_WIDTH_OFFSET = 12'h004;
    localparam logic [11:0] DRAW_ORIGIN_OFFSET = 12'h008;
    localparam logic [11:0] NAN_CULL_OFFSET = 12'h00c;
    localparam logic [11:0] DEGEN_CULL_OFFSET = 12'h010;
    localparam logic [11:0] OBJECT_COUNT_OFFSET = 12'h014;
    localparam logic [11:0] VIEWPORT_BASE = 12'h100;
    // viewport descriptor table: 16 entries, 32 bytes apart, 6 words used
    localparam int VIEWPORT_COUNT = 16;
    localparam int VIEWPORT_WORDS = 6;
    localparam logic [2:0] VP_M00 = 3'h0;
    localparam logic [2:0] VP_M11 = 3'h1;
    localparam logic [2:0] VP_M22 = 3'h2;
    localparam logic [2:0] VP_M30 = 3'h3;
    localparam logic [2:0] VP_M31 = 3'h4;
    localparam logic [2:0] VP_M32 = 3'h5;
    // control register fields
    localparam int CTRL_VIEWPORT_EN_BIT = 0;
    localparam int CTRL_BIAS_H_BIT = 1;
    localparam int CTRL_BIAS_V_BIT = 2;
    localparam int CTRL_FINE_SUBPIXEL_BIT = 3;
    localparam int CTRL_WIDTH_FROM_VERTEX_BIT = 4;
    localparam int CTRL_UPPER_LEFT_RULE_BIT = 5;
    localparam int CTRL_SOLID_FILL_BIT = 6;
    localparam int CTRL_WIDTH = 7;
    // reset values
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [15:0] POINT_WIDTH_RESET = 16'h0100;
    localparam logic [31:0] DRAW_ORIGIN_RESET = 32'h0000_0000;
    localparam logic [31:0] VIEWPORT_RESET = 32'h0000_0000;
    // fixed-point constants: positions are s15.16, output xy is s15.8
    localparam logic signed [33:0] HALF_PIXEL = 34'sh0_0000_8000;
    localparam logic signed [26:0] GUARD_MIN = -27'sd8388608;
    localparam logic signed [26:0] GUARD_MAX = 27'sd8388352;

    typedef enum logic [1:0] {
        POINT_LIST_TOPOLOGY,
        LINE_LIST_TOPOLOGY,
        TRIANGLE_LIST_TOPOLOGY,
        RECT_LIST_TOPOLOGY
    } topology_e;

    typedef enum logic [1:0] {
        POINT_OBJECT,
        LINE_OBJECT,
        TRIANGLE_OBJECT,
        RECTANGLE_OBJECT
    } object_kind_e;

    typedef enum {COLLECT, PROCESS, EMIT} setup_state_e;

    typedef struct packed {
        logic [31:0] x;
        logic [31:0] y;
        logic [31:0] z;
        logic [31:0] reciprocalW;
        logic [3:0] nanFlags;
        logic [3:0] viewportSelectIndex;
        logic [15:0] pointWidth;
        topology_e topology;
        logic primEnd;
    } vertex_s;

    typedef struct packed {
        object_kind_e objectKindTag;
        logic fineSubpixel;
        logic upperLeftEdgeRule;
        logic [3:0][23:0] x;
        logic [3:0][23:0] y;
        logic [3:0][31:0] z;
        logic [3:0][31:0] w;
    } object_s;
endpackage
`default_nettype wire

// ===== dv/raster_sink.sv
`timescale 1ns/100ps
`default_nettype none
// far-side rasterizer model: takes objects, can hold off
module raster_sink import setup_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stall,
    input wire logic objectValid,
    output logic objectReady,
    input wire object_s objectOut,
    output object_s lastObj,
    output logic [7:0] objCnt
);
    // ready is the inverse of stall, so a held object must stand unchanged
    assign objectReady = !stall;
    // keep the newest object and count them for the bench
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            objCnt <= 8'h00;
            lastObj <= '0;
        end else if (objectValid && objectReady) begin
            objCnt <= objCnt + 8'h01;
            lastObj <= objectOut;
        end
    end
endmodule // raster_sink
`default_nettype wire

// ===== dv/primitive_object_setup_test.sv
`timescale 1ns/100ps
`default_nettype none
module primitive_object_setup_test import setup_pkg::*; ;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic vertexValid = 1'b0, stall = 1'b1, pready, pslverr, vertexReady, objectValid, objectReady;
    logic [11:0] paddr = 12'h000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic err;
    vertex_s vertexIn = '0;
    object_s objectOut, lastObj;
    logic [7:0] objCnt;
    logic [3:0] vpSel = 4'h0;
    int errorCnt = 0, numChecks = 0;
    always #25 clk = !clk;
    primitive_object_setup dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .vertexValid, .vertexReady, .vertexIn,
        .objectValid, .objectReady, .objectOut);
    raster_sink sink (.clk, .rst_b, .stall, .objectValid, .objectReady, .objectOut,
        .lastObj, .objCnt);
    task automatic giveVerdict();
        if (errorCnt == 0 && numChecks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer; waits for pready, takes data at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one vertex in whole pixels; offered only while the block collects
    task automatic sendV(input int x, input int y, input topology_e t, input logic [3:0] nan);
        @(negedge clk);
        while (vertexReady !== 1'b1) @(negedge clk);
        @(posedge clk);
        vertexIn <= '{x << 16, y << 16, 32'h12345, 32'h10000, nan, vpSel, 16'h100, t, 1'b0};
        vertexValid <= 1'b1;
        @(posedge clk);
        vertexValid <= 1'b0;
    endtask
    // bounded wait until the sink holds n objects
    task automatic getObj(input logic [7:0] n);
        repeat (20) if (objCnt !== n) @(posedge clk);
        chk("objects", {24'h0, n}, {24'h0, objCnt});
    endtask
    // register answers, refused writes, read-back
    task automatic regsTest();
        chk("ready", 32'h1, {31'h0, pready});
        apb(1'b0, POINT_WIDTH_OFFSET, 32'h0);
        chk("width", 32'h100, rd);
        apb(1'b0, 12'h300, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, NAN_CULL_OFFSET, 32'h5);
        chk("counter write", 32'h1, {31'h0, err});
        apb(1'b1, DRAW_ORIGIN_OFFSET, 32'h0003_0002);
        apb(1'b0, DRAW_ORIGIN_OFFSET, 32'h0);
        chk("origin", 32'h0003_0002, rd);
    endtask
    // point square, held while the sink stalls
    task automatic pointTest();
        sendV(10, 20, POINT_LIST_TOPOLOGY, 4'h0);
        repeat (5) @(posedge clk);
        chk("held valid", 32'h1, {31'h0, objectValid});
        chk("held count", 32'h0, {24'h0, objCnt});
        stall <= 1'b0;
        getObj(8'h1);
        chk("lr x", 32'hc80, {8'h0, lastObj.x[0]});
        chk("lr y", 32'h1780, {8'h0, lastObj.y[0]});
        chk("ul x", 32'hb80, {8'h0, lastObj.x[2]});
        chk("ul y", 32'h1680, {8'h0, lastObj.y[2]});
        chk("z", 32'h12345, lastObj.z[3]);
    endtask
    // rectangle given as lr, ll, ul; upper right is built
    task automatic rectTest();
        sendV(30, 40, RECT_LIST_TOPOLOGY, 4'h0);
        sendV(10, 40, RECT_LIST_TOPOLOGY, 4'h0);
        sendV(10, 20, RECT_LIST_TOPOLOGY, 4'h0);
        getObj(8'h2);
        chk("kind", {30'h0, RECTANGLE_OBJECT}, {30'h0, lastObj.objectKindTag});
        chk("ur x", 32'h2000, {8'h0, lastObj.x[3]});
        chk("ur y", 32'h1700, {8'h0, lastObj.y[3]});
    endtask
    // dropped objects, then a square whose right edge leaves the guardband
    task automatic cullTest();
        repeat (3) sendV(5, 5, RECT_LIST_TOPOLOGY, 4'h0);
        sendV(1, 2, TRIANGLE_LIST_TOPOLOGY, 4'h0);
        sendV(3, 4, TRIANGLE_LIST_TOPOLOGY, 4'h0);
        sendV(5, 6, TRIANGLE_LIST_TOPOLOGY, 4'h8);
        sendV(32765, 20, POINT_LIST_TOPOLOGY, 4'h0);
        getObj(8'h3);
        chk("clamp", 32'h7fff00, {8'h0, lastObj.x[0]});
        chk("inside", 32'h7ffe80, {8'h0, lastObj.x[2]});
    endtask
    // collinear triangle passes without solid fill, is dropped with it
    task automatic fillTest();
        for (int i = 0; i < 3; i++) sendV(i, i, TRIANGLE_LIST_TOPOLOGY, 4'h0);
        getObj(8'h4);
        repeat (2) sendV(1, 1, LINE_LIST_TOPOLOGY, 4'h0);
        apb(1'b1, CTRL_OFFSET, 32'h40);
        for (int i = 0; i < 3; i++) sendV(i, i, TRIANGLE_LIST_TOPOLOGY, 4'h0);
    endtask
    // entry one transform, half bias, fine ties to even, vertex width
    task automatic viewportTest();
        apb(1'b1, VIEWPORT_BASE + 12'h020, 32'h0002_0000);
        apb(1'b1, VIEWPORT_BASE + 12'h024, 32'h0001_0000);
        apb(1'b1, VIEWPORT_BASE + 12'h02c, 32'h0004_0180);
        apb(1'b1, VIEWPORT_BASE + 12'h030, 32'h0000_0080);
        apb(1'b0, VIEWPORT_BASE + 12'h02c, 32'h0);
        chk("m30", 32'h0004_0180, rd);
        apb(1'b1, POINT_WIDTH_OFFSET, 32'h0300);
        apb(1'b1, CTRL_OFFSET, 32'h3f);
        vpSel <= 4'h1;
        sendV(10, 20, POINT_LIST_TOPOLOGY, 4'h0);
        getObj(8'h5);
        chk("vp lr x", 32'h1a02, {8'h0, lastObj.x[0]});
        chk("vp lr y", 32'h1700, {8'h0, lastObj.y[0]});
        chk("vp ul x", 32'h1902, {8'h0, lastObj.x[2]});
        chk("vp ul y", 32'h1600, {8'h0, lastObj.y[2]});
        chk("vp z", 32'h0, lastObj.z[0]);
        chk("flags", 32'h3, {30'h0, lastObj.fineSubpixel, lastObj.upperLeftEdgeRule});
        sendV(30000, 0, POINT_LIST_TOPOLOGY, 4'h0);
    endtask
    // statistics after every scenario
    task automatic countTest();
        apb(1'b0, NAN_CULL_OFFSET, 32'h0);
        chk("nan culls", 32'h2, rd);
        apb(1'b0, DEGEN_CULL_OFFSET, 32'h0);
        chk("degenerate culls", 32'h3, rd);
        apb(1'b0, OBJECT_COUNT_OFFSET, 32'h0);
        chk("emitted", 32'h5, rd);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        regsTest();
        pointTest();
        rectTest();
        cullTest();
        fillTest();
        viewportTest();
        countTest();
        giveVerdict();
    end
    // a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk);
        errorCnt++;
        giveVerdict();
    end
endmodule // primitive_object_setup_test
`default_nettype wire
